// ==== dcs_dma_ctrl.sv ====
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
//
// Contract
// - Any-event flag per channel sets on done, halfway or fault event; bits 0..24.
// - Done flag sets when channel finishes all transfers; bits 1..25.
// - Halfway flag sets when half the programmed transfers are done; bits 2..26.
// - Fault flag sets on a transfer error; bits 3..27.
// - Flags are hardware-set, read-only, held until cleared; bits 31:28 read zero.
// - Writing 1 to a channel's any-event clear clears all four flags.
// - Writing 1 to done clear bit clears only the done flag.
// - Writing 1 to halfway clear bit clears only the halfway flag.
// - Writing 1 to fault clear bit clears only the fault flag.
// - Writing 0 to clear bits leaves flags unchanged.
// - Configuration at 0x08 + 20*(channel-1), resets to zero.
// - Bit 0 enables channel; bits 1..3 enable done, halfway, fault interrupts.
// - Bit 4 selects direction: 0 peripheral to memory, 1 memory to peripheral.
// - Bits 6 and 7 enable peripheral and memory address increment.
// - Bits 9:8 give peripheral width 8, 16, 32 bits.
// - Bits 11:10 give memory width 8, 16, 32 bits.
// - Bits 13:12 give priority; arbiter picks highest priority first.
// - Bit 14 enables memory copy; bits 31:15 read zero.
// - Equal priority: lowest channel number wins.
// - Circular mode reloads count and base addresses at zero, keeps serving.
// - Count decrements per transfer; zero count means no transfer.
module dcs_dma_ctrl #(
	parameter int unsigned NUM_CH = dcs_pkg::NUM_CH_DEF
) (
	input  wire logic                sys_clk,
	input  wire logic                rstn,
	input  wire logic [7:0]          reg_addr,
	input  wire logic [31:0]         reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic      [31:0]         reg_rdata,
	input  wire logic [NUM_CH-1:0]   periph_req,
	output logic                     xfer_valid,
	output dcs_pkg::dcs_xfer_t       xfer_cmd,
	input  wire logic                xfer_done,
	input  wire logic                xfer_error,
	output logic      [NUM_CH-1:0]   irq
);

	if (NUM_CH < 1 || NUM_CH > dcs_pkg::NUM_CH_MAX) begin : g_bad_num_ch
		$error("NUM_CH must be 1 to 7");
	end

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	dcs_pkg::dcs_cfg_t   cfg_q    [NUM_CH];
	logic [15:0]         count_q  [NUM_CH];
	logic [15:0]         reload_q [NUM_CH];
	logic [31:0]         pbase_q  [NUM_CH];
	logic [31:0]         mbase_q  [NUM_CH];
	logic [31:0]         pcur_q   [NUM_CH];
	logic [31:0]         mcur_q   [NUM_CH];
	logic [3:0]          flag_q   [NUM_CH];
	logic [31:0]         ch_rd    [NUM_CH];
	logic [3:0]          clr_mask [NUM_CH];

	dcs_pkg::dcs_state_t state_q;
	dcs_pkg::dcs_xfer_t  cmd_q;
	dcs_pkg::dcs_xfer_t  cmd_d;
	logic                valid_q;
	logic [2:0]          act_q;
	logic [NUM_CH-1:0]   irq_q;
	logic [31:0]         rdata_q;

	logic [NUM_CH-1:0]   elig;
	logic [NUM_CH-1:0]   ev_done;
	logic [NUM_CH-1:0]   ev_half;
	logic [NUM_CH-1:0]   ev_fault;
	logic [NUM_CH-1:0]   ev_any;
	logic [NUM_CH-1:0]   irq_src;
	logic [NUM_CH-1:0]   done_vec;
	logic [NUM_CH-1:0]   half_vec;
	logic [NUM_CH-1:0]   fault_vec;
	logic [NUM_CH-1:0]   any_vec;
	logic [NUM_CH-1:0]   done_ie;
	logic [31:0]         status_w;
	logic [31:0]         clr_all_w;
	logic [31:0]         rd_or;
	logic [31:0]         rdata_d;
	logic                best_v;
	logic [2:0]          best_ch;
	logic [1:0]          best_pri;
	logic [31:0]         p_al;
	logic [31:0]         m_al;

	wire                 busy     = state_q == dcs_pkg::ST_BUSY;
	wire                 clr_wr   = reg_wr && reg_addr == dcs_pkg::CLEAR_OFF;
	wire                 resp_ok  = busy && xfer_done && !xfer_error;
	wire                 resp_err = busy && xfer_error;

	// Clear bits above the last channel nibble have no flag behind them
	assign clr_all_w[31:NUM_CH*4] = '0;

	assign reg_rdata  = rdata_q;
	assign xfer_valid = valid_q;
	assign xfer_cmd   = cmd_q;
	assign irq        = irq_q;

	function automatic logic [31:0] width_step(input dcs_pkg::dcs_width_t w);
		case (w)
			dcs_pkg::WID_8:  width_step = 32'h0000_0001;
			dcs_pkg::WID_16: width_step = 32'h0000_0002;
			default:         width_step = 32'h0000_0004;
		endcase
	endfunction

	// Low address bits are ignored for wide transfers
	function automatic logic [31:0] align(input logic [31:0] a, input dcs_pkg::dcs_width_t w);
		align = a & ~(width_step(w) - 32'h0000_0001);
	endfunction

	// ---------------------------------------------------------------
	// Per-channel registers, flags and counters
	// ---------------------------------------------------------------
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		localparam logic [7:0] OFS = 8'(c * int'(dcs_pkg::CH_STRIDE));

		wire       hit_cfg = reg_addr == dcs_pkg::CFG_OFF + OFS;
		wire       hit_cnt = reg_addr == dcs_pkg::COUNT_OFF + OFS;
		wire       hit_pa  = reg_addr == dcs_pkg::PADDR_OFF + OFS;
		wire       hit_ma  = reg_addr == dcs_pkg::MADDR_OFF + OFS;
		wire       en      = cfg_q[c].channel_enable_bit;
		// Count and address register writes are ignored while the channel is enabled
		wire       wr_cnt  = reg_wr && hit_cnt && !en;
		wire       wr_pa   = reg_wr && hit_pa && !en;
		wire       wr_ma   = reg_wr && hit_ma && !en;
		wire       mine    = act_q == 3'(c);
		wire       ok_c    = resp_ok && mine;
		wire       err_c   = resp_err && mine;
		wire [15:0] dec    = count_q[c] - 16'h0001;
		wire       wrap    = dec == 16'h0000 && cfg_q[c].circular_enable;
		wire [3:0] clr_nib = clr_wr ? reg_wdata[c*dcs_pkg::FLAG_STRIDE +: 4] : 4'h0;
		wire [3:0] set_nib = {ev_fault[c], ev_half[c], ev_done[c], ev_any[c]};

		assign ch_rd[c] = hit_cfg ? {17'h0, cfg_q[c]} :
		                  hit_cnt ? {16'h0, count_q[c]} :
		                  hit_pa  ? pbase_q[c] :
		                  hit_ma  ? mbase_q[c] : 32'h0;

		// zero count or disabled channel never competes
		assign elig[c] = en && count_q[c] != 16'h0000 &&
		                 (periph_req[c] || cfg_q[c].memory_copy_enable);

		// done when the last transfer completes
		assign ev_done[c]  = ok_c && dec == 16'h0000;
		// halfway point of the programmed count
		assign ev_half[c]  = ok_c && dec == (reload_q[c] >> 1);
		assign ev_fault[c] = err_c;
		assign ev_any[c]   = ev_done[c] | ev_half[c] | ev_fault[c];

		// any-event clear widens to the whole nibble
		assign clr_mask[c] = clr_nib[dcs_pkg::FLAG_ANY] ? 4'hf : clr_nib;
		assign clr_all_w[c*4 +: 4] = clr_mask[c];

		assign done_vec[c]  = flag_q[c][dcs_pkg::FLAG_DONE];
		assign half_vec[c]  = flag_q[c][dcs_pkg::FLAG_HALF];
		assign fault_vec[c] = flag_q[c][dcs_pkg::FLAG_FAULT];
		assign any_vec[c]   = flag_q[c][dcs_pkg::FLAG_ANY];
		assign done_ie[c]   = cfg_q[c].done_irq_enable;

		assign irq_src[c] = |(flag_q[c][3:1] & {cfg_q[c].fault_irq_enable,
		                      cfg_q[c].halfway_irq_enable, cfg_q[c].done_irq_enable});

		// set applied after the clear, so set wins
		always_ff @(posedge sys_clk or negedge rstn) begin
			if (!rstn) begin
				flag_q[c] <= dcs_pkg::FLAG_RST;
			end else begin
				flag_q[c] <= (flag_q[c] & ~clr_mask[c]) | set_nib;
			end
		end

		// configuration write; a fault stops the channel
		always_ff @(posedge sys_clk or negedge rstn) begin
			if (!rstn) begin
				cfg_q[c] <= dcs_pkg::CFG_RST;
			end else if (reg_wr && hit_cfg) begin
				cfg_q[c] <= dcs_pkg::dcs_cfg_t'(reg_wdata[dcs_pkg::CFG_W-1:0]);
			end else if (err_c) begin
				cfg_q[c].channel_enable_bit <= 1'b0;
			end
		end

		// decrement, or reload in circular mode
		always_ff @(posedge sys_clk or negedge rstn) begin
			if (!rstn) begin
				count_q[c]  <= dcs_pkg::COUNT_RST;
				reload_q[c] <= dcs_pkg::COUNT_RST;
			end else if (wr_cnt) begin
				count_q[c]  <= reg_wdata[15:0];
				reload_q[c] <= reg_wdata[15:0];
			end else if (ok_c) begin
				count_q[c]  <= wrap ? reload_q[c] : dec;
			end
		end

		// address stepping by width, reload to base on wrap
		always_ff @(posedge sys_clk or negedge rstn) begin
			if (!rstn) begin
				pbase_q[c] <= dcs_pkg::ADDR_RST;
				pcur_q[c]  <= dcs_pkg::ADDR_RST;
			end else if (wr_pa) begin
				pbase_q[c] <= reg_wdata;
				pcur_q[c]  <= reg_wdata;
			end else if (ok_c && wrap) begin
				pcur_q[c]  <= pbase_q[c];
			end else if (ok_c && cfg_q[c].peripheral_addr_increment) begin
				pcur_q[c]  <= pcur_q[c] + width_step(cfg_q[c].peripheral_width);
			end
		end

		always_ff @(posedge sys_clk or negedge rstn) begin
			if (!rstn) begin
				mbase_q[c] <= dcs_pkg::ADDR_RST;
				mcur_q[c]  <= dcs_pkg::ADDR_RST;
			end else if (wr_ma) begin
				mbase_q[c] <= reg_wdata;
				mcur_q[c]  <= reg_wdata;
			end else if (ok_c && wrap) begin
				mcur_q[c]  <= mbase_q[c];
			end else if (ok_c && cfg_q[c].memory_addr_increment) begin
				mcur_q[c]  <= mcur_q[c] + width_step(cfg_q[c].memory_width);
			end
		end
	end

	// ---------------------------------------------------------------
	// Arbiter
	// ---------------------------------------------------------------
	// strict greater-than keeps the lowest number on ties
	always_comb begin
		best_v   = 1'b0;
		best_ch  = 3'h0;
		best_pri = 2'h0;
		for (int i = 0; i < NUM_CH; i++) begin
			if (elig[i] && (!best_v || cfg_q[i].channel_priority > best_pri)) begin
				best_v   = 1'b1;
				best_ch  = 3'(i);
				best_pri = cfg_q[i].channel_priority;
			end
		end
	end

	// direction picks which side is the source
	assign p_al = align(pcur_q[best_ch], cfg_q[best_ch].peripheral_width);
	assign m_al = align(mcur_q[best_ch], cfg_q[best_ch].memory_width);

	always_comb begin
		cmd_d.chan      = best_ch;
		cmd_d.to_periph = cfg_q[best_ch].transfer_direction;
		cmd_d.mem_copy  = cfg_q[best_ch].memory_copy_enable;
		if (cfg_q[best_ch].transfer_direction) begin
			cmd_d.src_addr  = m_al;
			cmd_d.dst_addr  = p_al;
			cmd_d.src_width = cfg_q[best_ch].memory_width;
			cmd_d.dst_width = cfg_q[best_ch].peripheral_width;
		end else begin
			cmd_d.src_addr  = p_al;
			cmd_d.dst_addr  = m_al;
			cmd_d.src_width = cfg_q[best_ch].peripheral_width;
			cmd_d.dst_width = cfg_q[best_ch].memory_width;
		end
	end

	// ---------------------------------------------------------------
	// Transfer sequencer
	// ---------------------------------------------------------------
	// One transfer in flight; the grant is frozen until the far side answers
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= dcs_pkg::ST_IDLE;
			valid_q <= 1'b0;
			cmd_q   <= '0;
			act_q   <= 3'h0;
		end else begin
			case (state_q)
				dcs_pkg::ST_IDLE: begin
					if (best_v) begin
						state_q <= dcs_pkg::ST_BUSY;
						valid_q <= 1'b1;
						cmd_q   <= cmd_d;
						act_q   <= best_ch;
					end
				end
				dcs_pkg::ST_BUSY: begin
					if (xfer_done || xfer_error) begin
						state_q <= dcs_pkg::ST_IDLE;
						valid_q <= 1'b0;
					end
				end
				default: state_q <= dcs_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			irq_q <= '0;
		end else begin
			irq_q <= irq_src;
		end
	end

	// ---------------------------------------------------------------
	// Register read
	// ---------------------------------------------------------------
	// bits above the last channel nibble stay zero
	always_comb begin
		status_w = 32'h0;
		rd_or    = 32'h0;
		for (int i = 0; i < NUM_CH; i++) begin
			status_w[i*dcs_pkg::FLAG_STRIDE +: 4] = flag_q[i];
			rd_or = rd_or | ch_rd[i];
		end
	end

	assign rdata_d = (reg_addr == dcs_pkg::STATUS_OFF) ? status_w : rd_or;

	// Data only in the cycle after the strobe, zero otherwise
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= dcs_pkg::RDATA_RST;
		end else begin
			rdata_q <= reg_rd ? rdata_d : 32'h0;
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	property p_any_set;
		(|ev_any) |=> ((any_vec & $past(ev_any)) == $past(ev_any));
	endproperty
	a_any_set: assert property (p_any_set) else $error("any-event flag not set");

	property p_done_set;
		(|ev_done) |=> ((done_vec & $past(ev_done)) == $past(ev_done));
	endproperty
	a_done_set: assert property (p_done_set) else $error("done flag not set");

	property p_half_set;
		(|ev_half) |=> ((half_vec & $past(ev_half)) == $past(ev_half));
	endproperty
	a_half_set: assert property (p_half_set) else $error("halfway flag not set");

	property p_fault_set;
		resp_err |=> fault_vec[$past(act_q)] && !cfg_q[$past(act_q)].channel_enable_bit;
	endproperty
	a_fault_set: assert property (p_fault_set) else $error("fault not recorded");

	property p_clear;
		(clr_wr && ev_any == '0) |=> ((status_w & $past(clr_all_w)) == 32'h0);
	endproperty
	a_clear: assert property (p_clear) else $error("flag clear failed");

	property p_zero_write;
		(clr_wr && reg_wdata == 32'h0 && ev_any == '0) |=> $stable(status_w);
	endproperty
	a_zero_write: assert property (p_zero_write) else $error("zero write changed flags");

	property p_no_empty_xfer;
		$rose(valid_q) |-> count_q[cmd_q.chan] != 16'h0000 && cfg_q[cmd_q.chan].channel_enable_bit;
	endproperty
	a_no_empty_xfer: assert property (p_no_empty_xfer) else $error("empty transfer issued");

	property p_wrap;
		(resp_ok && count_q[act_q] == 16'h0001 && cfg_q[act_q].circular_enable)
			|=> count_q[$past(act_q)] == reload_q[$past(act_q)];
	endproperty
	a_wrap: assert property (p_wrap) else $error("circular reload missed");

	property p_done_irq;
		((done_vec & done_ie) != '0) |=> ((irq_q & $past(done_vec & done_ie)) != '0);
	endproperty
	a_done_irq: assert property (p_done_irq) else $error("done interrupt missing");

endmodule

// ==== dcs_far_side.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Request sources and memory responder
// ---------------------------------------------------------------
module dcs_far_side #(
	parameter int unsigned NUM_CH = 7
) (
	input  wire logic              sys_clk,
	input  wire logic              rstn,
	input  wire logic              xfer_valid,
	input  dcs_pkg::dcs_xfer_t     xfer_cmd,
	input  wire logic [NUM_CH-1:0] raise,
	input  wire logic [3:0]        lat,
	input  wire logic              fail,
	output logic      [NUM_CH-1:0] periph_req,
	output logic                   xfer_done,
	output logic                   xfer_error
);
	logic [3:0] cnt_q;

	// A request drops as its answer goes out, well before the re-grant edge
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= 4'h0;
			periph_req <= '0;
			xfer_done <= 1'b0;
			xfer_error <= 1'b0;
		end else begin
			xfer_done <= 1'b0;
			xfer_error <= 1'b0;
			periph_req <= periph_req | raise;
			if (xfer_valid && !xfer_done && !xfer_error) begin
				if (cnt_q == lat) begin
					cnt_q <= 4'h0;
					xfer_error <= fail;
					xfer_done <= !fail;
					periph_req <= (periph_req & ~(NUM_CH'(1) << xfer_cmd.chan)) | raise;
				end else begin
					cnt_q <= cnt_q + 4'h1;
				end
			end
		end
	end
endmodule

// ==== dcs_pkg.sv ====
package dcs_pkg;

	// ---------------------------------------------------------------
	// Sizes
	// ---------------------------------------------------------------
	localparam int unsigned NUM_CH_DEF  = 7;
	localparam int unsigned NUM_CH_MAX  = 7;
	localparam int unsigned ADDR_W      = 8;
	localparam int unsigned COUNT_W     = 16;
	localparam int unsigned CFG_W       = 15;
	localparam int unsigned CH_IDX_W    = 3;

	// ---------------------------------------------------------------
	// Register byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] STATUS_OFF   = 8'h00;
	localparam logic [7:0] CLEAR_OFF    = 8'h04;
	localparam logic [7:0] CFG_OFF      = 8'h08;
	localparam logic [7:0] COUNT_OFF    = 8'h0c;
	localparam logic [7:0] PADDR_OFF    = 8'h10;
	localparam logic [7:0] MADDR_OFF    = 8'h14;
	localparam logic [7:0] CH_STRIDE    = 8'h14;

	// ---------------------------------------------------------------
	// Flag nibble layout, one nibble per channel
	// ---------------------------------------------------------------
	localparam int unsigned FLAG_STRIDE = 4;
	localparam int unsigned FLAG_ANY    = 0;
	localparam int unsigned FLAG_DONE   = 1;
	localparam int unsigned FLAG_HALF   = 2;
	localparam int unsigned FLAG_FAULT  = 3;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [3:0]  FLAG_RST    = 4'h0;
	localparam logic [15:0] COUNT_RST   = 16'h0000;
	localparam logic [31:0] ADDR_RST    = 32'h0000_0000;
	localparam logic [31:0] RDATA_RST   = 32'h0000_0000;

	typedef enum logic [1:0] {
		WID_8   = 2'b00,
		WID_16  = 2'b01,
		WID_32  = 2'b10,
		WID_RSV = 2'b11
	} dcs_width_t;

	typedef enum logic {
		ST_IDLE,
		ST_BUSY
	} dcs_state_t;

	// Field order follows the configuration word, bit 14 down to bit 0
	typedef struct packed {
		logic       memory_copy_enable;
		logic [1:0] channel_priority;
		dcs_width_t memory_width;
		dcs_width_t peripheral_width;
		logic       memory_addr_increment;
		logic       peripheral_addr_increment;
		logic       circular_enable;
		logic       transfer_direction;
		logic       fault_irq_enable;
		logic       halfway_irq_enable;
		logic       done_irq_enable;
		logic       channel_enable_bit;
	} dcs_cfg_t;

	localparam dcs_cfg_t CFG_RST = '0;

	typedef struct packed {
		logic [2:0]  chan;
		logic [31:0] src_addr;
		logic [31:0] dst_addr;
		dcs_width_t  src_width;
		dcs_width_t  dst_width;
		logic        to_periph;
		logic        mem_copy;
	} dcs_xfer_t;

endpackage

// ==== dma_channel_control_status_bench.sv ====
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
	$display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module dma_channel_control_status_bench;
	logic               sys_clk = 1'b0;
	logic               rstn = 1'b0;
	logic [7:0]         reg_addr = 8'h00;
	logic [31:0]        reg_wdata = 32'h0;
	logic               reg_wr = 1'b0;
	logic               reg_rd = 1'b0;
	logic [31:0]        reg_rdata;
	logic [6:0]         periph_req;
	logic               xfer_valid;
	dcs_pkg::dcs_xfer_t xfer_cmd;
	logic               xfer_done;
	logic               xfer_error;
	logic [6:0]         irq;
	logic [6:0]         raise = 7'h00;
	logic [3:0]         lat = 4'h3;
	logic               fail = 1'b0;
	int                 error_cnt = 0;
	int                 check_count = 0;

	always #50 sys_clk = ~sys_clk;

	dcs_dma_ctrl #(.NUM_CH(7)) dcs_dma_ctrl_i (.sys_clk(sys_clk), .rstn(rstn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .periph_req(periph_req), .xfer_valid(xfer_valid),
		.xfer_cmd(xfer_cmd), .xfer_done(xfer_done), .xfer_error(xfer_error), .irq(irq));
	dcs_far_side #(.NUM_CH(7)) dcs_far_side_i (.sys_clk(sys_clk), .rstn(rstn),
		.xfer_valid(xfer_valid), .xfer_cmd(xfer_cmd), .raise(raise), .lat(lat),
		.fail(fail), .periph_req(periph_req), .xfer_done(xfer_done),
		.xfer_error(xfer_error));

	// ---------------------------------------------------------------
	// Bus and transfer tasks
	// ---------------------------------------------------------------
	function automatic logic [7:0] cfg_a(input int ch);
		return 8'(8'h08 + 20 * (ch - 1));
	endfunction

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe edge
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		`CHK(reg_rdata, exp)
	endtask

	task automatic kick(input logic [6:0] m);
		@(posedge sys_clk);
		raise <= m;
		@(posedge sys_clk);
		raise <= 7'h00;
	endtask

	task automatic xfer(input logic [2:0] c, input logic [31:0] s, input logic [31:0] d,
		input dcs_pkg::dcs_width_t w, input logic tp, input logic mc);
		dcs_pkg::dcs_xfer_t e;
		int n;
		e = '{chan: c, src_addr: s, dst_addr: d, src_width: w, dst_width: w,
			to_periph: tp, mem_copy: mc};
		n = 0;
		while (xfer_valid !== 1'b1 && n < 50) begin
			@(negedge sys_clk);
			n++;
		end
		`CHK(xfer_cmd, e)
		while (xfer_valid !== 1'b0 && n < 100) begin
			@(negedge sys_clk);
			n++;
		end
		`CHK(n < 100, 1'b1)
	endtask

	task automatic test_done;
		$display("checks=%0d errors=%0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		test_done();
	end

	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		repeat (4) @(posedge sys_clk);
		rstn <= 1'b1;
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		rd(8'hf0, 32'h0);
		for (int ch = 1; ch <= 7; ch++) begin
			rd(cfg_a(ch), 32'h0);
			wr(cfg_a(ch), 32'hffff_ffff);
			rd(cfg_a(ch), 32'h0000_7fff);
			`CHK(xfer_valid, 1'b0)
			wr(cfg_a(ch), 32'h0);
		end
		// Channel 1: two words, both addresses stepping by four
		wr(8'h0c, 32'h2);
		wr(8'h10, 32'h100);
		wr(8'h14, 32'h200);
		wr(8'h08, 32'hac7);
		kick(7'h01);
		xfer(3'd0, 32'h100, 32'h200, dcs_pkg::WID_32, 1'b0, 1'b0);
		rd(8'h00, 32'h5);
		`CHK(irq, 7'h01)
		kick(7'h01);
		xfer(3'd0, 32'h104, 32'h204, dcs_pkg::WID_32, 1'b0, 1'b0);
		rd(8'h00, 32'h7);
		rd(8'h0c, 32'h0);
		wr(8'h04, 32'h4);
		rd(8'h00, 32'h3);
		wr(8'h04, 32'h0);
		rd(8'h00, 32'h3);
		wr(8'h04, 32'h2);
		rd(8'h00, 32'h1);
		wr(8'h04, 32'h1);
		rd(8'h00, 32'h0);
		// Empty count keeps an enabled, requesting channel idle
		kick(7'h01);
		repeat (5) @(negedge sys_clk);
		`CHK(xfer_valid, 1'b0)
		// Channel 2: prompt error answer
		fail <= 1'b1;
		lat <= 4'h0;
		wr(8'h20, 32'h1);
		wr(8'h1c, 32'h9);
		kick(7'h02);
		xfer(3'd1, 32'h0, 32'h0, dcs_pkg::WID_8, 1'b0, 1'b0);
		rd(8'h00, 32'h90);
		`CHK(irq, 7'h02)
		wr(8'h04, 32'h80);
		rd(8'h00, 32'h10);
		wr(8'h04, 32'h10);
		rd(8'h00, 32'h0);
		fail <= 1'b0;
		// Channels 3, 5, 6 request together
		wr(8'h34, 32'h1);
		wr(8'h30, 32'h1);
		wr(8'h5c, 32'h1);
		wr(8'h58, 32'h2001);
		wr(8'h74, 32'h30);
		wr(8'h78, 32'h60);
		wr(8'h70, 32'h1);
		wr(8'h6c, 32'h2011);
		kick(7'h34);
		xfer(3'd4, 32'h0, 32'h0, dcs_pkg::WID_8, 1'b0, 1'b0);
		xfer(3'd5, 32'h60, 32'h30, dcs_pkg::WID_8, 1'b1, 1'b0);
		xfer(3'd2, 32'h0, 32'h0, dcs_pkg::WID_8, 1'b0, 1'b0);
		rd(8'h00, 32'h0077_0700);
		wr(8'h04, 32'h0fff_ffff);
		rd(8'h00, 32'h0);
		// Channel 4 circular, memory address fixed
		lat <= 4'h2;
		wr(8'h48, 32'h2);
		wr(8'h4c, 32'h40);
		wr(8'h50, 32'h80);
		wr(8'h44, 32'h561);
		kick(7'h08);
		xfer(3'd3, 32'h40, 32'h80, dcs_pkg::WID_16, 1'b0, 1'b0);
		kick(7'h08);
		xfer(3'd3, 32'h42, 32'h80, dcs_pkg::WID_16, 1'b0, 1'b0);
		rd(8'h48, 32'h2);
		kick(7'h08);
		xfer(3'd3, 32'h40, 32'h80, dcs_pkg::WID_16, 1'b0, 1'b0);
		// Channel 7 memory copy runs with no request
		wr(8'h84, 32'h1);
		wr(8'h80, 32'h4001);
		xfer(3'd6, 32'h0, 32'h0, dcs_pkg::WID_8, 1'b0, 1'b1);
		// Channel 4 done clear lands on the edge of its done event: set wins
		kick(7'h08);
		repeat (3) @(posedge sys_clk);
		wr(8'h04, 32'h0000_2000);
		rd(8'h00, 32'h0700_7000);
		test_done();
	end
endmodule
